// ### core/sdt_regs.svh
`ifndef SDT_REGS_SVH
`define SDT_REGS_SVH

// Register byte offsets.
`define SDT_OFF_HCTL2   8'h00
`define SDT_OFF_SRST    8'h04
`define SDT_OFF_PSTATE  8'h08
`define SDT_OFF_ERR     8'h0C
`define SDT_OFF_AUTO    8'h10
`define SDT_OFF_BGC     8'h14

// Field positions.
`define SDT_B_EXEC      0
`define SDT_B_SCS       1
`define SDT_B_SR_CMD    0
`define SDT_B_SR_DAT    1
`define SDT_B_ERR_DTO   4
`define SDT_B_AUTO_NX   0
`define SDT_B_AUTO_NI   7
`define SDT_B_BG_STOP   0
`define SDT_B_BG_CONT   1
`define SDT_B_BG_RWAIT  2
`define SDT_B_BG_ADMA   3

// Reset values.
`define SDT_RST_SRST    2'h0
`define SDT_RST_ERR     7'h00
`define SDT_RST_PINS    6'h1F

// Timing and counts.
`define SDT_CLK_MHZ     20
`define SDT_SETTLE_US   40
`define SDT_SETTLE_CYC  (`SDT_SETTLE_US * `SDT_CLK_MHZ)
`define SDT_SRST_CYC    3'h4
`define SDT_TUNE_MAX    40
`define SDT_FIXED_TAP   3'h4
`define SDT_CMD_TUNE_SD 6'h13
`define SDT_CMD_TUNE_MM 6'h15

`endif

// ### core/sdt_pkg.sv
package sdt_pkg;

	typedef enum logic [2:0] {
		SDT_TS_IDLE = 3'b001,
		SDT_TS_RUN  = 3'b010,
		SDT_TS_END  = 3'b100
	} sdt_tune_state_t;

	typedef logic [2:0] sdt_tap_t;

endpackage

// ### core/sdt_tune_if.sv
`timescale 1ns/1ps
interface sdt_tune_if;
	logic              start;
	logic              stop;
	logic              try_done;
	logic              try_ok;
	logic              busy;
	logic              pass;
	logic              fail;
	sdt_pkg::sdt_tap_t tap;

	modport eng (input start, stop, try_done, try_ok, output busy, pass, fail, tap);
	modport ctl (output start, stop, try_done, try_ok, input busy, pass, fail, tap);
endinterface

// ### core/sdt_pin_sync.sv
`timescale 1ns/1ps
`include "sdt_regs.svh"
module sdt_pin_sync (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       ce,
	// Pins: bit 5 link clock, bit 4 command, bits 3:0 data
	input  wire logic [5:0] pin_in,
	output logic      [5:0] pin_sync,
	output logic            clk_rise
);
	import sdt_pkg::*;

	logic [5:0] stage1;
	logic       clk_d;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1   <= `SDT_RST_PINS;
			pin_sync <= `SDT_RST_PINS;
			clk_d    <= 1'b0;
		end else if (ce) begin
			stage1   <= pin_in;
			pin_sync <= stage1;
			clk_d    <= pin_sync[5];
		end
	end

	assign clk_rise = pin_sync[5] & ~clk_d;
endmodule

// ### core/sdt_tune_engine.sv
`timescale 1ns/1ps
`include "sdt_regs.svh"
module sdt_tune_engine (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic ce,
	// Control side
	sdt_tune_if.eng   tif
);
	import sdt_pkg::*;

	sdt_tune_state_t state;
	sdt_tune_state_t next_state;
	logic [5:0]      tries;
	sdt_tap_t        tap;
	logic            pass_r;

	wire last_try = (tries == 6'(`SDT_TUNE_MAX - 1));
	wire hit      = tif.try_done & tif.try_ok;

	always_comb begin
		next_state = state;
		unique case (state)
			SDT_TS_IDLE: next_state = tif.start ? SDT_TS_RUN : SDT_TS_IDLE;
			SDT_TS_RUN: begin
				if (tif.stop)
					next_state = SDT_TS_IDLE;
				else if (hit || (tif.try_done && last_try))
					next_state = SDT_TS_END;
			end
			SDT_TS_END: next_state = SDT_TS_IDLE;
			default: next_state = SDT_TS_IDLE;
		endcase
	end

	// The tap sweeps one step per failed try, so a pass leaves the good tap held.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state  <= SDT_TS_IDLE;
			tries  <= 6'h00;
			tap    <= 3'h0;
			pass_r <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			if (state == SDT_TS_IDLE && tif.start) begin
				tries <= 6'h00;
				tap   <= 3'h0;
			end else if (state == SDT_TS_RUN && tif.try_done) begin
				pass_r <= tif.try_ok;
				if (!tif.try_ok) begin
					tries <= tries + 6'h01;
					tap   <= tap + 3'h1;
				end
			end
		end
	end

	assign tif.busy = (state != SDT_TS_IDLE);
	assign tif.pass = (state == SDT_TS_END) & pass_r;
	assign tif.fail = (state == SDT_TS_END) & ~pass_r;
	assign tif.tap  = tap;
endmodule

// ### core/sdt_recovery_ctrl.sv
`timescale 1ns/1ps
`include "sdt_regs.svh"
module sdt_recovery_ctrl (
	// Clock, enable and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Bus pins
	input  wire logic        sd_clk,
	input  wire logic        sd_cmd,
	input  wire logic [3:0]  sd_dat,
	// Command and data path events
	input  wire logic        cmd_issue,
	input  wire logic        cmd_uses_dat,
	input  wire logic [5:0]  cmd_idx,
	input  wire logic        cmd_done,
	input  wire logic        xfer_done,
	input  wire logic [3:0]  err_cmd,
	input  wire logic [2:0]  err_dat,
	input  wire logic        tune_done,
	input  wire logic        tune_ok,
	input  wire logic        auto12_not_exec,
	input  wire logic        auto12_not_issued,
	input  wire logic        card_read_wait,
	// Line control
	output logic             cmd_line_rst,
	output logic             dat_line_rst,
	output logic             stop_at_gap,
	output logic             continue_req,
	output logic             suspend_ok,
	output logic             use_tuned_clk,
	// Sampled bus
	output logic             smp_cmd,
	output logic      [3:0]  smp_dat,
	output logic             smp_valid
);
	import sdt_pkg::*;

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic is_tune_cmd(input logic [5:0] idx);
		is_tune_cmd = (idx == `SDT_CMD_TUNE_SD) || (idx == `SDT_CMD_TUNE_MM);
	endfunction

	// Submodules.
	sdt_tune_if tif ();

	sdt_tune_engine u_tune (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.tif     (tif)
	);

	logic [5:0] pin_sync;
	logic       clk_rise;

	sdt_pin_sync u_sync (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.ce       (ce),
		.pin_in   ({sd_clk, sd_cmd, sd_dat}),
		.pin_sync (pin_sync),
		.clk_rise (clk_rise)
	);

	wire [3:0] dat_lvl = pin_sync[3:0];

	// Bus decode.
	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr      = req & wb_we_i;
	wire [31:0] wmask   = lane_mask(wb_sel_i);
	wire [31:0] wbits   = wb_dat_i & wmask;
	wire        sel_hc  = (wb_adr_i == `SDT_OFF_HCTL2);
	wire        sel_sr  = (wb_adr_i == `SDT_OFF_SRST);
	wire        sel_ps  = (wb_adr_i == `SDT_OFF_PSTATE);
	wire        sel_er  = (wb_adr_i == `SDT_OFF_ERR);
	wire        sel_au  = (wb_adr_i == `SDT_OFF_AUTO);
	wire        sel_bg  = (wb_adr_i == `SDT_OFF_BGC);
	wire        wr_hc   = wr & sel_hc;
	wire        wr_sr   = wr & sel_sr;
	wire        wr_er   = wr & sel_er;
	wire        wr_au   = wr & sel_au;
	wire        wr_bg   = wr & sel_bg;

	// State.
	logic       exec;
	logic       scs;
	logic [1:0] srst;
	logic [2:0] srst_cnt [2];
	logic       inh_cmd;
	logic       inh_dat;
	logic [6:0] err;
	logic [1:0] auto_st;
	logic       bg_stop;
	logic       bg_rwait;
	logic       bg_adma;
	logic [9:0] settle_cnt;
	logic [2:0] phase;
	logic       armed;

	// Tuning control.
	wire scs_wr0  = wr_hc & wmask[`SDT_B_SCS] & ~wb_dat_i[`SDT_B_SCS];
	wire tune_req = wr_hc & wbits[`SDT_B_EXEC] & scs_wr0 & ~exec;
	wire tune_end = tif.pass | tif.fail | srst[`SDT_B_SR_CMD];

	wire next_exec = tune_req | (exec & ~tune_end);
	// A pass in the same cycle as a software write of 0 wins.
	wire next_scs  = tif.pass | (scs & ~scs_wr0);

	assign tif.start    = tune_req;
	assign tif.stop     = srst[`SDT_B_SR_CMD];
	// Software keeps sending tuning commands; each finished block is a try.
	assign tif.try_done = tune_done & exec;
	assign tif.try_ok   = tune_ok;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			exec <= 1'b0;
			scs  <= 1'b0;
		end else if (ce) begin
			exec <= next_exec;
			scs  <= next_scs;
		end
	end

	assign use_tuned_clk = scs;

	// Sampling point: tuned tap or the fixed tap, counted from the link clock rise.
	// The tap resolution is one system clock, which bounds how fine tuning can be.
	wire [2:0] tap_sel = scs ? tif.tap : `SDT_FIXED_TAP;
	wire       hit     = armed & (phase == tap_sel);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase <= 3'h0;
			armed <= 1'b0;
		end else if (ce) begin
			phase <= clk_rise ? 3'h0 : ((phase == 3'h7) ? phase : phase + 3'h1);
			armed <= clk_rise | (armed & ~hit);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			smp_cmd   <= 1'b1;
			smp_dat   <= 4'hF;
			smp_valid <= 1'b0;
		end else if (ce) begin
			smp_valid <= hit;
			if (hit) begin
				smp_cmd <= pin_sync[4];
				smp_dat <= dat_lvl;
			end
		end
	end

	// Software resets: each line holds its reset for a few cycles, then self-clears.
	wire [1:0] srst_go = {2{wr_sr}} & wbits[1:0] & ~srst;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			srst <= `SDT_RST_SRST;
			for (int i = 0; i < 2; i++)
				srst_cnt[i] <= 3'h0;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (srst_go[i]) begin
					srst[i]     <= 1'b1;
					srst_cnt[i] <= `SDT_SRST_CYC;
				end else if (srst[i]) begin
					if (srst_cnt[i] == 3'h1)
						srst[i] <= 1'b0;
					srst_cnt[i] <= srst_cnt[i] - 3'h1;
				end
			end
		end
	end

	assign cmd_line_rst = srst[`SDT_B_SR_CMD];
	assign dat_line_rst = srst[`SDT_B_SR_DAT];

	// Command inhibits; a new command wins over a completion in the same cycle.
	wire next_inh_cmd = cmd_issue | (inh_cmd & ~cmd_done & ~cmd_line_rst);
	wire next_inh_dat = (cmd_issue & cmd_uses_dat)
		| (inh_dat & ~xfer_done & ~dat_line_rst);

	// Error status. Responses to tuning commands raise nothing while tuning runs.
	wire       quiet   = exec & is_tune_cmd(cmd_idx);
	wire [6:0] err_set = {err_dat, err_cmd} & {7{~quiet}};
	wire [6:0] err_clr = wr_er ? wbits[6:0] : 7'h00;
	wire [6:0] next_err = err_set | (err & ~err_clr);

	wire [1:0] au_set = {auto12_not_issued, auto12_not_exec};
	wire [1:0] au_clr = wr_au ? {wbits[`SDT_B_AUTO_NI], wbits[`SDT_B_AUTO_NX]} : 2'h0;
	wire [1:0] next_auto = au_set | (auto_st & ~au_clr);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			inh_cmd <= 1'b0;
			inh_dat <= 1'b0;
			err     <= `SDT_RST_ERR;
			auto_st <= 2'h0;
		end else if (ce) begin
			inh_cmd <= next_inh_cmd;
			inh_dat <= next_inh_dat;
			err     <= next_err;
			auto_st <= next_auto;
		end
	end

	// Data lines must stay high for the whole settle time before they count as free.
	wire dat_high = (dat_lvl == 4'hF);
	wire settled  = (settle_cnt == 10'(`SDT_SETTLE_CYC));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			settle_cnt <= 10'h000;
		else if (ce)
			settle_cnt <= !dat_high ? 10'h000 : (settled ? settle_cnt : settle_cnt + 10'h001);
	end

	// Block gap control. Continue is a one-cycle request and reads back 0.
	wire cont_go = wr_bg & wbits[`SDT_B_BG_CONT] & ~wb_dat_i[`SDT_B_BG_STOP];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bg_stop      <= 1'b0;
			bg_rwait     <= 1'b0;
			bg_adma      <= 1'b0;
			continue_req <= 1'b0;
		end else if (ce) begin
			continue_req <= cont_go;
			if (dat_line_rst) begin
				bg_stop <= 1'b0;
			end else if (wr_bg && wmask[0]) begin
				bg_stop  <= wb_dat_i[`SDT_B_BG_STOP];
				bg_rwait <= wb_dat_i[`SDT_B_BG_RWAIT];
				bg_adma  <= wb_dat_i[`SDT_B_BG_ADMA];
			end
		end
	end

	assign stop_at_gap = bg_stop;
	assign suspend_ok  = bg_rwait & card_read_wait & ~bg_adma;

	// Read data. Error bits 3:0 come from err_cmd and bits 6:4 from err_dat.
	wire [31:0] rd_hc = {30'h0, scs, exec};
	wire [31:0] rd_sr = {30'h0, srst};
	wire [31:0] rd_ps = {23'h0, tif.busy, dat_lvl, suspend_ok, settled, inh_dat, inh_cmd};
	wire [31:0] rd_er = {25'h0, err};
	wire [31:0] rd_au = {24'h0, auto_st[1], 6'h00, auto_st[0]};
	wire [31:0] rd_bg = {28'h0, bg_adma, bg_rwait, 1'b0, bg_stop};
	wire [31:0] rdata = sel_hc ? rd_hc : sel_sr ? rd_sr : sel_ps ? rd_ps :
		sel_er ? rd_er : sel_au ? rd_au : sel_bg ? rd_bg : 32'h0000_0000;

	// Every access, mapped or not, is answered one cycle after it is seen.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= rdata;
		end
	end
endmodule

// ### testbench/sdt_props.sv
`timescale 1ns/1ps
`include "sdt_regs.svh"
module sdt_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        ce,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// Events and controls
	input wire logic        tune_done,
	input wire logic        tune_ok,
	input wire logic        card_read_wait,
	input wire logic        cmd_line_rst,
	input wire logic        dat_line_rst,
	input wire logic        continue_req,
	input wire logic        suspend_ok,
	input wire logic        use_tuned_clk,
	input wire logic        smp_valid
);
	// A low clock enable freezes the block, so the checks pause with it.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn || !ce);
	wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        scs0 = take && wb_we_i && wb_adr_i == `SDT_OFF_HCTL2 && !wb_dat_i[1];
	logic [2:0] ok_age;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			ok_age <= 3'h7;
		else if (tune_done && tune_ok)
			ok_age <= 3'h0;
		else if (ok_age != 3'h7)
			ok_age <= ok_age + 3'h1;
	end
	property p_ack; take |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_cmd_rst; $rose(cmd_line_rst) |-> cmd_line_rst[*4] ##1 !cmd_line_rst; endproperty
	a_cmd_rst: assert property (p_cmd_rst) else $error("cmd reset length");
	property p_dat_rst; $rose(dat_line_rst) |-> ##[1:8] !dat_line_rst; endproperty
	a_dat_rst: assert property (p_dat_rst) else $error("dat reset stuck");
	property p_cont; continue_req |=> !continue_req; endproperty
	a_cont: assert property (p_cont) else $error("continue too long");
	property p_susp; suspend_ok |-> card_read_wait; endproperty
	a_susp: assert property (p_susp) else $error("suspend without read wait");
	property p_tuned; $rose(use_tuned_clk) |-> ok_age < 3'h5; endproperty
	a_tuned: assert property (p_tuned) else $error("tuned clock without success");
	property p_fixed; scs0 |=> !use_tuned_clk; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed clock not restored");
	property p_smp; smp_valid |=> !smp_valid[*4]; endproperty
	a_smp: assert property (p_smp) else $error("sample strobe too often");
	cover property ($rose(use_tuned_clk));
	cover property ($fell(dat_line_rst));
	cover property (continue_req);
	cover property (smp_valid);
endmodule
bind sdt_recovery_ctrl sdt_props u_props (.*);

// ### testbench/sdt_card_model.sv
`timescale 1ns/1ps
module sdt_card_model (
	// Frame control
	input  wire logic       frame,
	input  wire logic [3:0] dat_lvl,
	// Bus lines
	output logic            sd_clk,
	output logic            sd_cmd,
	output logic      [3:0] sd_dat
);
	// Pull-ups lift released lines, so idle holds the command and all data lines high.
	assign sd_cmd = frame ? ^dat_lvl : 1'b1;
	assign sd_dat = frame ? dat_lvl : 4'hF;
	initial begin
		sd_clk = 1'b0;
		forever begin
			wait (frame);
			#37;
			while (frame) begin
				#200 sd_clk = 1'b1;
				#200 sd_clk = 1'b0;
			end
		end
	end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "sdt_regs.svh"
module tb;
	import sdt_pkg::*;
	logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, frame = 1'b0;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF, err_cmd = 4'h0, sd_dat, smp_dat, dat_lvl = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, w, m_err = 32'h0;
	logic [5:0]  cmd_idx = 6'h00;
	logic [2:0]  err_dat = 3'h0;
	logic        cmd_issue = 1'b0, cmd_uses_dat = 1'b0, cmd_done = 1'b0, xfer_done = 1'b0;
	logic        tune_done = 1'b0, tune_ok = 1'b0, card_read_wait = 1'b0;
	logic        auto12_not_exec = 1'b0, auto12_not_issued = 1'b0;
	logic        sd_clk, sd_cmd, cmd_line_rst, dat_line_rst, stop_at_gap, continue_req;
	logic        suspend_ok, use_tuned_clk, smp_cmd, smp_valid;
	integer      errors = 0, total_checks = 0, n, i, conts = 0, smps = 0;
	sdt_recovery_ctrl dut (.*);
	sdt_card_model card (.*);
	initial forever #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		conts <= conts + continue_req;
		smps <= smps + smp_valid;
	end
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Called just after a rising edge; the request stands until ack is seen.
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			test_done();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask
	task tune(input logic ok);
		tune_done <= 1'b1;
		tune_ok <= ok;
		@(posedge clk_sys);
		tune_done <= 1'b0;
		@(posedge clk_sys);
	endtask
	initial begin
		n = $urandom(2576);
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'hFFFF_FFFF, 32'h0000_00F0, "pstate");
		rd(`SDT_OFF_HCTL2, 32'hFFFF_FFFF, 32'h0, "hctl2");
		wb(1'b1, 8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'hFFFF_FFFF, 32'h0, "unmapped");
		$display("test reset done");
		wb(1'b1, `SDT_OFF_HCTL2, 32'h1);
		cmd_idx <= `SDT_CMD_TUNE_SD;
		err_cmd <= 4'hF;
		@(posedge clk_sys);
		err_cmd <= 4'h0;
		for (i = 0; i < 3; i++) tune(1'b0);
		tune(1'b1);
		repeat (3) @(posedge clk_sys);
		rd(`SDT_OFF_HCTL2, 32'h3, 32'h2, "tune pass");
		chk("tuned", 32'h1, {31'h0, use_tuned_clk});
		rd(`SDT_OFF_ERR, 32'hFF, 32'h0, "tune errors");
		wb(1'b1, `SDT_OFF_HCTL2, 32'h0);
		chk("fixed", 32'h0, {31'h0, use_tuned_clk});
		wb(1'b1, `SDT_OFF_HCTL2, 32'h1);
		for (i = 1; i < `SDT_TUNE_MAX; i++) tune(1'b0);
		rd(`SDT_OFF_HCTL2, 32'h3, 32'h1, "tune running");
		tune(1'b0);
		repeat (3) @(posedge clk_sys);
		rd(`SDT_OFF_HCTL2, 32'h3, 32'h0, "tune fail");
		$display("test tuning done");
		cmd_idx <= 6'h0C;
		for (i = 0; i < 3; i++) begin
			w = $urandom & 32'h7F;
			m_err = m_err | w;
			err_cmd <= w[3:0];
			err_dat <= w[6:4];
			@(posedge clk_sys);
			err_cmd <= 4'h0;
			err_dat <= 3'h0;
			@(posedge clk_sys);
			rd(`SDT_OFF_ERR, 32'hFF, m_err, "err set");
			w = $urandom & 32'h7F;
			wb(1'b1, `SDT_OFF_ERR, w);
			m_err = m_err & ~w;
			rd(`SDT_OFF_ERR, 32'hFF, m_err, "err clear");
		end
		$display("test errors done");
		cmd_uses_dat <= 1'b1;
		cmd_issue <= 1'b1;
		@(posedge clk_sys);
		cmd_issue <= 1'b0;
		@(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'h3, 32'h3, "inhibit both");
		cmd_done <= 1'b1;
		@(posedge clk_sys);
		cmd_done <= 1'b0;
		@(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'h3, 32'h2, "inhibit dat");
		xfer_done <= 1'b1;
		@(posedge clk_sys);
		xfer_done <= 1'b0;
		@(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'h3, 32'h0, "inhibit none");
		wb(1'b1, `SDT_OFF_SRST, 32'h3);
		i = 0;
		do begin
			wb(1'b0, `SDT_OFF_SRST, 32'h0);
			i++;
		end while (q[1:0] !== 2'h0 && i < 20);
		chk("soft reset", 32'h0, q);
		$display("test abort done");
		auto12_not_exec <= 1'b1;
		auto12_not_issued <= 1'b1;
		@(posedge clk_sys);
		auto12_not_exec <= 1'b0;
		auto12_not_issued <= 1'b0;
		@(posedge clk_sys);
		rd(`SDT_OFF_AUTO, 32'hFF, 32'h81, "auto");
		wb(1'b1, `SDT_OFF_AUTO, 32'h1);
		rd(`SDT_OFF_AUTO, 32'hFF, 32'h80, "auto clear");
		card_read_wait <= 1'b1;
		wb(1'b1, `SDT_OFF_BGC, 32'h5);
		chk("gap", 32'h1, {31'h0, stop_at_gap});
		chk("suspend", 32'h1, {31'h0, suspend_ok});
		wb(1'b1, `SDT_OFF_BGC, 32'hD);
		chk("suspend adma", 32'h0, {31'h0, suspend_ok});
		wb(1'b1, `SDT_OFF_BGC, 32'h2);
		@(posedge clk_sys);
		chk("continue", 32'h1, conts);
		$display("test gap done");
		dat_lvl <= 4'($urandom) & 4'hE;
		frame <= 1'b1;
		repeat (60) @(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'hF4, {24'h0, dat_lvl, 4'h0}, "dat low");
		chk("sampled", {28'h0, dat_lvl}, {28'h0, smp_dat});
		chk("sampled cmd", {31'h0, ^dat_lvl}, {31'h0, smp_cmd});
		chk("samples", 32'h1, {31'h0, smps > 5 && smps < 9});
		frame <= 1'b0;
		repeat (`SDT_SETTLE_CYC + 20) @(posedge clk_sys);
		rd(`SDT_OFF_PSTATE, 32'hF4, 32'hF4, "dat high");
		$display("test link done");
		test_done();
	end
endmodule
